/* File: rtl/isra_pkg.sv */
// shared constants and types for the two-wire register access link
// Operation
// - slave never holds the clock line low
// - general call address is never acknowledged
// - no device identification response at all
// - normal rates to 1MHz, fast after engage
// - power-up and stop restore normal filters
// - master engages fast mode by code byte
// - fast code is not acknowledged, filters switch
// - fast mode survives repeated start, ends stop
// - repeated start keeps current filter setting
// - transfers open with address and write bit
// - own address acknowledged on ninth clock
// - pointer byte acknowledged and stored
// - write byte acknowledged, committed on SDA rise
// - further write bytes go to next register
// - last write byte acked like the others
// - read uses repeated start, then data out
// - master ack asks for next register
// - master nack ends read, slave releases SDA
// - pointer kept across stop condition
// - only the selected main address is acknowledged
// - every pointer value is acknowledged
// - bytes go msb first, then ack bit
package isra_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_NORM_PERIOD_NS = 1000;
    // quarter of the shortest legal normal-mode period, rounded up
    localparam int SCL_QTR_CYC = (SCL_NORM_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ---------------------------------------------------------------
    // byte framing and addresses
    // ---------------------------------------------------------------
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BYTE_END = 4'h9;
    localparam logic [6:0] MAIN_ADDR0 = 7'h40;
    localparam logic [6:0] MAIN_ADDR1 = 7'h48;
    localparam logic [6:0] MAIN_ADDR2 = 7'h44;
    localparam logic [6:0] MAIN_ADDR3 = 7'h4C;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [7:0] HS_CODE_BYTE = 8'h08;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] READ_FILL = 8'hFF;
    // slave protocol phases
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_RD, PH_SKIP} isra_phase_t;
    // master bus operations
    typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP, OP_END} isra_op_t;
endpackage

/* File: rtl/isra_link_if.sv */
// open-drain two-wire link joining the slave and master ends
`timescale 1ns/1ns
`default_nettype none
interface isra_link_if;
    logic mstSclOut;
    logic mstSclOeN;
    logic mstSdaOut;
    logic mstSdaOeN;
    logic devSdaOut;
    logic devSdaOeN;
    wire scl;
    wire sda;
    // wired-and with pull-up: a low enable means the end drives its out value
    assign scl = mstSclOeN | mstSclOut;
    assign sda = (mstSdaOeN | mstSdaOut) & (devSdaOeN | devSdaOut);
    modport dev (input scl, input sda, output devSdaOut, output devSdaOeN);
    modport mst (input scl, input sda, output mstSclOut, output mstSclOeN,
                 output mstSdaOut, output mstSdaOeN);
endinterface
`default_nettype wire

/* File: rtl/isra_slave.sv */
// register access slave end of the two-wire link
`timescale 1ns/1ns
`default_nettype none
module isra_slave
    import isra_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    isra_link_if.dev bus,
    input wire logic [1:0] addrSel,
    output logic regWrEn,
    output logic [7:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic [7:0] regRdAddr,
    input wire logic [7:0] regRdData,
    output logic hsMode
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [6:0] mainAddrOf(input logic [1:0] sel);
        case (sel)
            2'h0: mainAddrOf = MAIN_ADDR0;
            2'h1: mainAddrOf = MAIN_ADDR1;
            2'h2: mainAddrOf = MAIN_ADDR2;
            default: mainAddrOf = MAIN_ADDR3;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic sclMeta_q, sclSync_q, sclPrev_q;
    logic sdaMeta_q, sdaSync_q, sdaPrev_q;
    logic sclRise, sclFall, sdaRise, startDet, stopDet;

    // three flops per pin; edges are found on the settled copies only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclMeta_q <= bus.scl;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= bus.sda;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    // line events; sda edges count as control only while scl stays high
    assign sclRise = sclSync_q & ~sclPrev_q;
    assign sclFall = ~sclSync_q & sclPrev_q;
    assign sdaRise = sdaSync_q & ~sdaPrev_q;
    assign startDet = ~sdaSync_q & sdaPrev_q & sclSync_q & sclPrev_q;
    assign stopDet = sdaRise & sclSync_q & sclPrev_q;

    // ---------------------------------------------------------------
    // address strap, caught after reset release
    // ---------------------------------------------------------------
    logic strapDone_q, strapDone_d;
    logic [6:0] ownAddr_q, ownAddr_d;

    always_comb begin
        strapDone_d = 1'b1;
        ownAddr_d = strapDone_q ? ownAddr_q : mainAddrOf(addrSel);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strapDone_q <= 1'b0;
            ownAddr_q <= MAIN_ADDR0;
        end else begin
            strapDone_q <= strapDone_d;
            ownAddr_q <= ownAddr_d;
        end
    end

    // ---------------------------------------------------------------
    // protocol engine
    // ---------------------------------------------------------------
    isra_phase_t phase_q, phase_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] pendAddr_q, pendAddr_d;
    logic [7:0] pendData_q, pendData_d;
    logic pend_q, pend_d;
    logic wrEn_q, wrEn_d;
    logic [7:0] wrAddr_q, wrAddr_d;
    logic [7:0] wrData_q, wrData_d;
    logic hs_q, hs_d;
    logic sdaOeN_q, sdaOeN_d;

    // sampling on scl rise, driving on scl fall; the slave only ever
    // touches sda, scl is an input here
    always_comb begin
        phase_d = phase_q;
        bitCnt_d = bitCnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        pendAddr_d = pendAddr_q;
        pendData_d = pendData_q;
        pend_d = pend_q;
        wrEn_d = 1'b0;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        hs_d = hs_q;
        sdaOeN_d = sdaOeN_q;
        // a held byte becomes active on the next sda rise, stop included
        if (pend_q && sdaRise) begin
            wrEn_d = 1'b1;
            wrAddr_d = pendAddr_q;
            wrData_d = pendData_q;
            pend_d = 1'b0;
        end
        if (startDet) begin
            // repeated start leaves hs_q alone
            phase_d = PH_ADDR;
            bitCnt_d = 4'h0;
            sdaOeN_d = 1'b1;
        end else if (stopDet) begin
            // pointer deliberately untouched here
            phase_d = PH_IDLE;
            hs_d = 1'b0;
            sdaOeN_d = 1'b1;
        end else if (phase_q != PH_IDLE && phase_q != PH_SKIP) begin
            if (sclRise) begin
                bitCnt_d = bitCnt_q + 4'h1;
                if (bitCnt_q < ACK_SLOT) begin
                    rx_d = {rx_q[6:0], sdaSync_q}; // msb first
                end else if (phase_q == PH_RD) begin
                    if (sdaSync_q) begin
                        phase_d = PH_SKIP; // master nack ends the read
                    end else begin
                        ptr_d = ptr_q + 8'h01; // next register on ack
                    end
                end
            end else if (sclFall) begin
                if (bitCnt_q == ACK_SLOT) begin
                    case (phase_q)
                        // only the strapped address; general call, fast code
                        // and the id query all fall through unanswered
                        PH_ADDR: sdaOeN_d = (rx_q[7:1] != ownAddr_q);
                        PH_PTR: sdaOeN_d = 1'b0; // any pointer value
                        PH_WR: sdaOeN_d = 1'b0;
                        default: sdaOeN_d = 1'b1; // read: master answers
                    endcase
                end else if (bitCnt_q == BYTE_END) begin
                    bitCnt_d = 4'h0;
                    sdaOeN_d = 1'b1;
                    case (phase_q)
                        PH_ADDR: begin
                            if (rx_q[7:3] == HS_CODE_TOP) begin
                                hs_d = 1'b1;
                                phase_d = PH_SKIP;
                            end else if (rx_q[7:1] != ownAddr_q) begin
                                phase_d = PH_SKIP;
                            end else if (rx_q[0]) begin
                                phase_d = PH_RD;
                                sdaOeN_d = regRdData[7];
                                tx_d = {regRdData[6:0], 1'b1};
                            end else begin
                                phase_d = PH_PTR;
                            end
                        end
                        PH_PTR: begin
                            ptr_d = rx_q;
                            phase_d = PH_WR;
                        end
                        PH_WR: begin
                            // the master's ack slot level is never inspected
                            // an older byte never seen committed goes out now
                            if (pend_q) begin
                                wrEn_d = 1'b1;
                                wrAddr_d = pendAddr_q;
                                wrData_d = pendData_q;
                            end
                            pend_d = 1'b1;
                            pendAddr_d = ptr_q;
                            pendData_d = rx_q;
                            ptr_d = ptr_q + 8'h01;
                        end
                        PH_RD: begin
                            // pointer already stepped, so regRdData is the next one
                            sdaOeN_d = regRdData[7];
                            tx_d = {regRdData[6:0], 1'b1};
                        end
                        default: phase_d = PH_SKIP;
                    endcase
                end else if (phase_q == PH_RD) begin
                    if (bitCnt_q < ACK_SLOT) begin
                        sdaOeN_d = tx_q[7];
                        tx_d = {tx_q[6:0], 1'b1};
                    end else begin
                        sdaOeN_d = 1'b1;
                    end
                end
            end
        end
    end

    // plain registering; pointer starts at zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_q <= PH_IDLE;
            bitCnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'hFF;
            ptr_q <= PTR_RESET;
            pendAddr_q <= 8'h00;
            pendData_q <= 8'h00;
            pend_q <= 1'b0;
            wrEn_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
            hs_q <= 1'b0;
            sdaOeN_q <= 1'b1;
        end else begin
            phase_q <= phase_d;
            bitCnt_q <= bitCnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            pendAddr_q <= pendAddr_d;
            pendData_q <= pendData_d;
            pend_q <= pend_d;
            wrEn_q <= wrEn_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            hs_q <= hs_d;
            sdaOeN_q <= sdaOeN_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs straight from flops; sda drive level tied low
    // ---------------------------------------------------------------
    // hsMode selects the input filter set; this engine itself runs at any
    // rate its core clock can resolve, about an eighth of core_clk
    assign regWrEn = wrEn_q;
    assign regWrAddr = wrAddr_q;
    assign regWrData = wrData_q;
    assign regRdAddr = ptr_q;
    assign hsMode = hs_q;
    assign bus.devSdaOut = 1'b0;
    assign bus.devSdaOeN = sdaOeN_q;
endmodule // isra_slave
`default_nettype wire

/* File: rtl/isra_master.sv */
// bus master end: one register write or read per request
`timescale 1ns/1ns
`default_nettype none
module isra_master
    import isra_pkg::*;
#(
    parameter int QTR_CYC = SCL_QTR_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    isra_link_if.mst bus,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic reqHs,
    input wire logic [6:0] reqAddr,
    input wire logic [7:0] reqPtr,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic doneValid,
    output logic [7:0] rspData,
    output logic rspNack
);
    if (QTR_CYC < SCL_QTR_CYC || QTR_CYC > 255) begin : g_chk
        $error("QTR_CYC would break the normal-mode rate or the divider");
    end

    // ---------------------------------------------------------------
    // sequence decode: optional fast code, then address/pointer/data
    // ---------------------------------------------------------------
    function automatic isra_op_t opOf(input logic [3:0] n, input logic rd);
        case (n)
            4'h0: opOf = OP_START;
            4'h1, 4'h2: opOf = OP_BYTE;
            4'h3: opOf = rd ? OP_START : OP_BYTE; // repeated start for read
            4'h4: opOf = rd ? OP_BYTE : OP_STOP;
            4'h5: opOf = rd ? OP_BYTE : OP_END;
            4'h6: opOf = rd ? OP_STOP : OP_END;
            default: opOf = OP_END;
        endcase
    endfunction

    function automatic logic [7:0] byteOf(input logic [3:0] n, input logic rd,
                                          input logic [6:0] a, input logic [7:0] p,
                                          input logic [7:0] d);
        case (n)
            4'h1: byteOf = {a, 1'b0};
            4'h2: byteOf = p;
            4'h3: byteOf = d;
            4'h4: byteOf = {a, 1'b1};
            default: byteOf = READ_FILL; // read byte: sda left released
        endcase
    endfunction

    // ---------------------------------------------------------------
    // engine
    // ---------------------------------------------------------------
    logic sdaMeta_q, sdaSync_q;
    logic busy_q, busy_d;
    logic [7:0] div_q, div_d;
    logic [1:0] qtr_q, qtr_d;
    logic [3:0] seq_q, seq_d;
    logic [3:0] bitIdx_q, bitIdx_d;
    logic [8:0] rx_q, rx_d;
    logic rd_q, rd_d, hs_q, hs_d;
    logic [6:0] addr_q, addr_d;
    logic [7:0] ptr_q, ptr_d, data_q, data_d;
    logic sclOeN_q, sclOeN_d, sdaOeN_q, sdaOeN_d;
    logic done_q, done_d, nack_q, nack_d;
    logic [7:0] rsp_q, rsp_d;
    logic [3:0] norm;
    logic inCode, tick;
    isra_op_t op;
    logic [7:0] curByte;

    // the fast code occupies two leading steps: start and code byte
    assign inCode = hs_q && (seq_q < 4'h2);
    assign norm = hs_q ? (seq_q - 4'h2) : seq_q;
    assign op = inCode ? ((seq_q == 4'h0) ? OP_START : OP_BYTE) : opOf(norm, rd_q);
    assign curByte = inCode ? HS_CODE_BYTE : byteOf(norm, rd_q, addr_q, ptr_q, data_q);
    assign tick = (div_q == 8'(QTR_CYC - 1));

    // sda pin synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
        end else begin
            sdaMeta_q <= bus.sda;
            sdaSync_q <= sdaMeta_q;
        end
    end

    // each bus bit spans four quarters; scl is ours alone, never sensed
    always_comb begin
        busy_d = busy_q;
        div_d = tick ? 8'h00 : div_q + 8'h01;
        qtr_d = qtr_q;
        seq_d = seq_q;
        bitIdx_d = bitIdx_q;
        rx_d = rx_q;
        rd_d = rd_q;
        hs_d = hs_q;
        addr_d = addr_q;
        ptr_d = ptr_q;
        data_d = data_q;
        sclOeN_d = sclOeN_q;
        sdaOeN_d = sdaOeN_q;
        done_d = 1'b0;
        nack_d = nack_q;
        rsp_d = rsp_q;
        if (!busy_q) begin
            div_d = 8'h00;
            if (reqValid) begin
                busy_d = 1'b1;
                rd_d = reqRead;
                hs_d = reqHs;
                addr_d = reqAddr;
                ptr_d = reqPtr;
                data_d = reqData;
                seq_d = 4'h0;
                qtr_d = 2'h0;
                bitIdx_d = 4'h0;
                nack_d = 1'b0;
            end
        end else if (op == OP_END) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            if (rd_q) begin
                rsp_d = rx_q[8:1];
            end
        end else if (tick) begin
            qtr_d = qtr_q + 2'h1;
            case (qtr_q)
                2'h0: begin
                    if (op == OP_START) begin
                        sdaOeN_d = 1'b1;
                    end else if (op == OP_STOP) begin
                        sdaOeN_d = 1'b0;
                    end else if (bitIdx_q < ACK_SLOT) begin
                        sdaOeN_d = curByte[3'(4'h7 - bitIdx_q)]; // msb first
                    end else begin
                        sdaOeN_d = 1'b1; // ack slot; read byte gets nack
                    end
                end
                2'h1: sclOeN_d = 1'b1;
                2'h2: begin
                    if (op == OP_START) begin
                        sdaOeN_d = 1'b0;
                    end else if (op == OP_STOP) begin
                        sdaOeN_d = 1'b1; // stop; slave restores normal filters
                    end else begin
                        rx_d = {rx_q[7:0], sdaSync_q};
                    end
                end
                default: begin
                    if (op != OP_STOP) begin
                        sclOeN_d = 1'b0;
                    end
                    if (op == OP_BYTE && bitIdx_q < ACK_SLOT) begin
                        bitIdx_d = bitIdx_q + 4'h1;
                    end else begin
                        bitIdx_d = 4'h0;
                        seq_d = seq_q + 4'h1;
                        // fast code and our own read byte go unanswered; others need
                        // an ack, whatever value the byte holds
                        if (op == OP_BYTE && !inCode && !(rd_q && norm == 4'h5) && rx_q[0]) begin
                            nack_d = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            div_q <= 8'h00;
            qtr_q <= 2'h0;
            seq_q <= 4'h0;
            bitIdx_q <= 4'h0;
            rx_q <= 9'h1FF;
            rd_q <= 1'b0;
            hs_q <= 1'b0;
            addr_q <= 7'h00;
            ptr_q <= 8'h00;
            data_q <= 8'h00;
            sclOeN_q <= 1'b1;
            sdaOeN_q <= 1'b1;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            rsp_q <= 8'h00;
        end else begin
            busy_q <= busy_d;
            div_q <= div_d;
            qtr_q <= qtr_d;
            seq_q <= seq_d;
            bitIdx_q <= bitIdx_d;
            rx_q <= rx_d;
            rd_q <= rd_d;
            hs_q <= hs_d;
            addr_q <= addr_d;
            ptr_q <= ptr_d;
            data_q <= data_d;
            sclOeN_q <= sclOeN_d;
            sdaOeN_q <= sdaOeN_d;
            done_q <= done_d;
            nack_q <= nack_d;
            rsp_q <= rsp_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reqReady = ~busy_q;
    assign doneValid = done_q;
    assign rspData = rsp_q;
    assign rspNack = nack_q;
    assign bus.mstSclOut = 1'b0;
    assign bus.mstSclOeN = sclOeN_q;
    assign bus.mstSdaOut = 1'b0;
    assign bus.mstSdaOeN = sdaOeN_q;
endmodule // isra_master
`default_nettype wire

/* File: verif/isra_link_monitor.sv */
// wire-level checker for the link between master and slave
`timescale 1ns/1ns
`default_nettype none
module isra_link_monitor
    import isra_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [6:0] ownAddr,
    input wire logic scl,
    input wire logic sda,
    input wire logic mstSclOeN,
    input wire logic devSdaOeN
);
    // ----------
    // bit and byte tracking
    // ----------
    logic sclD_q, sdaD_q, wrHit_q, rdHit_q, rise, bit8, addrEnd;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    assign rise = scl && !sclD_q;
    assign bit8 = rise && bit_q == 4'h8;
    assign addrEnd = bit8 && byte_q == 2'h0;
    // restart on every start, so a repeated start realigns the byte count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {sclD_q, sdaD_q, bit_q, byte_q, wrHit_q, rdHit_q, sh_q} <= 18'h3_0000;
        end else begin
            sclD_q <= scl;
            sdaD_q <= sda;
            if (sclD_q && scl && sdaD_q && !sda) begin
                {bit_q, byte_q, wrHit_q, rdHit_q} <= 8'h00;
            end else if (rise) begin
                sh_q <= {sh_q[6:0], sda};
                bit_q <= bit8 ? 4'h0 : bit_q + 4'h1;
                byte_q <= (bit8 && byte_q != 2'h3) ? byte_q + 2'h1 : byte_q;
                wrHit_q <= addrEnd ? sh_q == {ownAddr, 1'b0} : wrHit_q;
                rdHit_q <= addrEnd ? sh_q == {ownAddr, 1'b1} : rdHit_q;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_NO_STRETCH: assert property (!scl |-> !mstSclOeN)
        else $error("clock low without master");
    AST_OWN_ACK: assert property (addrEnd && sh_q[7:1] == ownAddr |-> !devSdaOeN)
        else $error("own address not acked");
    AST_FOREIGN_NACK: assert property (addrEnd && sh_q[7:1] != ownAddr |-> devSdaOeN)
        else $error("foreign address acked");
    AST_WRITE_ACK: assert property (bit8 && wrHit_q |-> !devSdaOeN)
        else $error("write byte not acked");
    AST_READ_FREE: assert property (bit8 && rdHit_q |-> devSdaOeN)
        else $error("slave held ack slot of read");
    AST_BITS_FREE: assert property (rise && !bit8 && !rdHit_q |-> devSdaOeN)
        else $error("slave drove a data bit");
    AST_STABLE_HIGH: assert property (scl && sclD_q |-> $stable(devSdaOeN))
        else $error("slave moved data while clock high");
    AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*3])
        else $error("clock high phase too short");
    COV_READ: cover property (bit8 && rdHit_q);
    COV_HS: cover property (addrEnd && sh_q == HS_CODE_BYTE);
    COV_STOP: cover property (sclD_q && scl && !sdaD_q && sda);
endmodule // isra_link_monitor
`default_nettype wire

/* File: verif/i2c_slave_register_access_tb.sv */
// bench: master and slave ends joined over one link
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_register_access_tb;
    import isra_pkg::*;
    logic [1:0] sel = 2'h2;
    logic [6:0] own = MAIN_ADDR2;
    logic core_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqRead = 1'b0, reqHs = 1'b0;
    logic reqReady, doneValid, rspNack, regWrEn, hsMode, hsSeen;
    logic [6:0] reqAddr = 7'h00;
    logic [7:0] reqPtr = 8'h00, reqData = 8'h00, rspData, regWrAddr, regWrData, regRdAddr;
    logic [7:0] expAddr, expData, p, d;
    logic [7:0] regs [256];
    logic [7:0] model [256];
    logic [6:0] bad [7] = '{7'h00, 7'h7C, 7'h49, MAIN_ADDR0, MAIN_ADDR1, MAIN_ADDR3, 7'h45};
    int errors = 0, testsRun = 0, cycles = 0, wrCnt = 0, w;
    isra_link_if link();
    isra_slave i_isra_slave (.core_clk(core_clk), .rst(rst), .bus(link.dev), .addrSel(sel),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regRdAddr(regRdAddr), .regRdData(regs[regRdAddr]), .hsMode(hsMode));
    isra_master i_isra_master (.core_clk(core_clk), .rst(rst), .bus(link.mst),
        .reqValid(reqValid), .reqRead(reqRead), .reqHs(reqHs), .reqAddr(reqAddr),
        .reqPtr(reqPtr), .reqData(reqData), .reqReady(reqReady), .doneValid(doneValid),
        .rspData(rspData), .rspNack(rspNack));
    isra_link_monitor i_isra_link_monitor (.core_clk(core_clk), .ownAddr(own),
        .rst(rst), .scl(link.scl), .sda(link.sda), .mstSclOeN(link.mstSclOeN),
        .devSdaOeN(link.devSdaOeN));
    initial forever #50 core_clk = ~core_clk;
    // expected main address for each strap setting
    function automatic logic [6:0] addrFor(input logic [1:0] s);
        case (s)
            2'h0: return MAIN_ADDR0;
            2'h1: return MAIN_ADDR1;
            2'h2: return MAIN_ADDR2;
            default: return MAIN_ADDR3;
        endcase
    endfunction
    task automatic chk(input logic [7:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one request; fast mode must be off again well after the last stop
    task automatic xfer(input logic rd, hs, input logic [6:0] a, input logic [7:0] pp, dd);
        int n = 0;
        @(posedge core_clk);
        #1;
        chk({7'h00, hsMode}, 8'h00);
        {reqValid, reqRead, reqHs, reqAddr, reqPtr, reqData} = {1'b1, rd, hs, a, pp, dd};
        {expAddr, expData, hsSeen} = {pp, dd, 1'b0};
        @(posedge core_clk);
        #1 reqValid = 1'b0;
        // look just after each edge so the one-cycle done pulse is seen settled
        while (doneValid !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk({7'h00, doneValid}, 8'h01);
        if (!rd && a == own) model[pp] = dd;
    endtask
    // write strobes fill the register file; the cycle ceiling cuts a hang
    always @(posedge core_clk) begin
        cycles++;
        if (hsMode === 1'b1) hsSeen = 1'b1;
        if (regWrEn === 1'b1) begin
            wrCnt++;
            chk(regWrAddr, expAddr);
            chk(regWrData, expData);
            regs[regWrAddr] <= regWrData;
        end
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(11));
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h5A ^ 8'(i);
            model[i] = 8'h5A ^ 8'(i);
        end
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        chk(regRdAddr, PTR_RESET);
        chk({7'h00, reqReady}, 8'h01);
        // random writes with both pointer ends, each read straight back
        for (int k = 0; k < 6; k++) begin
            p = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
            d = 8'($urandom);
            w = wrCnt;
            xfer(1'b0, k[0], own, p, d);
            chk({7'h00, rspNack}, 8'h00);
            chk(8'(wrCnt - w), 8'h01);
            chk(regRdAddr, p + 8'h01);
            chk({7'h00, hsSeen}, {7'h00, k[0]});
            xfer(1'b1, k[1], own, p, 8'h00);
            chk(rspData, model[p]);
            chk(regRdAddr, p);
            chk({7'h00, hsSeen}, {7'h00, k[1]});
        end
        // refused: general call, id query, test mode, other straps
        foreach (bad[j]) begin
            w = wrCnt;
            xfer(1'b0, 1'b0, bad[j], 8'h10, 8'hA5);
            chk({7'h00, rspNack}, 8'h01);
            chk(8'(wrCnt - w), 8'h00);
        end
        // second reset with another strap; the old address must fall silent
        sel = 2'($urandom) | 2'h1;
        @(posedge core_clk);
        #1 rst = 1'b1;
        own = addrFor(sel);
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        chk(regRdAddr, PTR_RESET);
        w = wrCnt;
        xfer(1'b0, 1'b0, own, 8'h33, 8'hC3);
        chk({7'h00, rspNack}, 8'h00);
        chk(8'(wrCnt - w), 8'h01);
        xfer(1'b0, 1'b0, MAIN_ADDR2, 8'h34, 8'h3C);
        chk({7'h00, rspNack}, 8'h01);
        chk(8'(wrCnt - w), 8'h01);
        conclude();
    end
endmodule // i2c_slave_register_access_tb
`default_nettype wire
